/* rtl/trcd_pkg.sv */
// constants and types shared by the timing receiver command decoder
package trcd_pkg;

  // identity and frame field widths
  localparam int ID_W   = 14;
  localparam int BYTE_W = 8;
  localparam int QUAL_W = 4;
  localparam int PIN_W  = 16;

  // internal sub-addresses of addressed commands
  localparam logic [7:0] SUB_FINE_ONE  = 8'h00;
  localparam logic [7:0] SUB_FINE_TWO  = 8'h01;
  localparam logic [7:0] SUB_COARSE    = 8'h02;
  localparam logic [7:0] SUB_CONTROL   = 8'h03;
  localparam logic [7:0] SUB_ERR_DUMP  = 8'h04;
  localparam logic [7:0] SUB_CFG_DUMP  = 8'h05;
  localparam logic [7:0] SUB_RESET     = 8'h06;

  // generic address accepted by every receiver
  localparam logic [ID_W-1:0] ID_GENERIC = 14'h0000;

  // register reset values
  localparam logic [7:0] FINE_ONE_RST = 8'h00;
  localparam logic [7:0] FINE_TWO_RST = 8'h00;
  localparam logic [7:0] COARSE_RST   = 8'h00;
  localparam logic [7:0] CONTROL_RST  = 8'h00;

  // field positions
  localparam int CTRL_CLK_SEL_BIT = 2;
  localparam int COARSE_LOW_LSB   = 0;
  localparam int COARSE_USER_LSB  = 4;
  localparam int DLY_W            = 4;
  localparam int BC_BUNCH_BIT     = 0;
  localparam int BC_EVENT_BIT     = 1;
  localparam int BC_SYS_LSB       = 2;
  localparam int BC_SYS_W         = 4;
  localparam int BC_USER_LSB      = 6;
  localparam int BC_USER_W        = 2;
  localparam int ID_HIGH_LSB      = 8;

  // data qualifier codes
  localparam logic [QUAL_W-1:0] QUAL_NONE      = 4'h0;
  localparam logic [QUAL_W-1:0] QUAL_ERR_FIRST = 4'h1;
  localparam logic [QUAL_W-1:0] QUAL_CFG_FIRST = 4'h5;
  localparam logic [2:0]        ERR_LAST_IDX   = 3'h3;
  localparam logic [2:0]        CFG_LAST_IDX   = 3'h5;

  // dump sequencer modes
  typedef enum logic [1:0] {
    DMP_IDLE = 2'b00,
    DMP_ERR  = 2'b01,
    DMP_CFG  = 2'b10
  } trcd_dump_t;

endpackage

/* rtl/trcd_dly_if.sv */
// carrier between the decoder and one coarse delay line
`timescale 1ns/1ps
`default_nettype none
interface trcd_dly_if #(
  parameter int W  = 1,
  parameter int DW = 4
);
  logic [W-1:0]  din;
  logic [DW-1:0] delay;
  logic [W-1:0]  dout;

  modport src (output din, output delay, input dout);
  modport dly (input din, input delay, output dout);
endinterface
`default_nettype wire

/* rtl/trcd_delay_line.sv */
// programmable coarse delay line, one tap per clock step
`timescale 1ns/1ps
`default_nettype none
module trcd_delay_line #(
  parameter int W     = 1,
  parameter int DW    = 4,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rstn_in,
  // delay port
  trcd_dly_if.dly   dl
);
  import trcd_pkg::*;

  if (DEPTH != (1 << DW)) begin : g_chk
    $error("delay depth must equal two to the delay width");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] stage;
  } trcd_dly_state_t;

  trcd_dly_state_t st_ff;
  trcd_dly_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.stage[0] = dl.din;
    for (int i = 1; i < DEPTH; i++) begin
      nxt_st.stage[i] = st_ff.stage[i-1];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // tap selected by the programmed step count
  assign dl.dout = st_ff.stage[dl.delay];
endmodule
`default_nettype wire

/* rtl/trcd_decoder.sv */
// timing receiver command decoder: addressed and broadcast frames
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module trcd_decoder (
  // clock and reset
  input  wire logic                        clk_sys_in,
  input  wire logic                        rstn_in,
  // identity source, sampled once after reset release
  input  wire logic                        id_from_prom_in,
  input  wire logic [trcd_pkg::ID_W-1:0]   id_prom_in,
  input  wire logic [trcd_pkg::PIN_W-1:0]  id_pins_in,
  // addressed command frame, checked upstream
  input  wire logic                        addr_frame_valid_in,
  input  wire logic [trcd_pkg::ID_W-1:0]   addr_frame_id_in,
  input  wire logic                        addr_frame_ext_in,
  input  wire logic [trcd_pkg::BYTE_W-1:0] addr_frame_sub_in,
  input  wire logic [trcd_pkg::BYTE_W-1:0] addr_frame_data_in,
  // broadcast frame
  input  wire logic                        bcast_valid_in,
  input  wire logic [trcd_pkg::BYTE_W-1:0] bcast_data_in,
  // error counters for the dump
  input  wire logic [15:0]                 single_err_count_in,
  input  wire logic [7:0]                  double_err_count_in,
  input  wire logic [7:0]                  upset_err_count_in,
  // external output buses, shared with identity pins
  output logic                             ext_bus_oe_out,
  output logic [trcd_pkg::BYTE_W-1:0]      ext_subaddress_field_out,
  output logic [trcd_pkg::BYTE_W-1:0]      ext_data_out,
  output logic [trcd_pkg::QUAL_W-1:0]      ext_qual_out,
  output logic                             ext_data_strobe_out,
  // internal registers and commands
  output logic [trcd_pkg::BYTE_W-1:0]      fine_delay_one_out,
  output logic [trcd_pkg::BYTE_W-1:0]      fine_delay_two_out,
  output logic [trcd_pkg::BYTE_W-1:0]      coarse_delay_out,
  output logic [trcd_pkg::BYTE_W-1:0]      control_out,
  output logic                             user_clock_select_out,
  output logic                             reset_request_out,
  output logic                             bunch_count_clear_out,
  output logic                             event_count_clear_out,
  // broadcast outputs
  output logic                             bunch_clear_strobe_out,
  output logic                             event_clear_strobe_out,
  output logic [7:2]                       broadcast_out,
  output logic                             broadcast_strobe_low_out,
  output logic                             broadcast_strobe_user_out
);
  import trcd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic                  id_loaded;
    logic [ID_W-1:0]       id;
    logic [BYTE_W-1:0]     fine_one;
    logic [BYTE_W-1:0]     fine_two;
    logic [BYTE_W-1:0]     coarse;
    logic [BYTE_W-1:0]     control;
    trcd_dump_t            dump;
    logic [2:0]            idx;
    logic [BYTE_W-1:0]     sub;
    logic [BYTE_W-1:0]     dat;
    logic [QUAL_W-1:0]     qual;
    logic                  stb;
    logic                  rst_req;
    logic                  bunch_clr;
    logic                  event_clr;
    logic                  bclr_stb;
    logic                  eclr_stb;
    logic                  lo_stb;
    logic                  usr_stb;
    logic [BC_SYS_W-1:0]   sys;
    logic [BC_USER_W-1:0]  usr;
  } trcd_state_t;

  trcd_state_t st_ff;
  trcd_state_t nxt_st;

  // byte and qualifier carried by a dump step
  function automatic logic [BYTE_W+QUAL_W-1:0] dump_word(
    input trcd_dump_t  mode,
    input logic [2:0]  idx,
    input trcd_state_t s
  );
    logic [BYTE_W-1:0] b;
    logic [QUAL_W-1:0] q;
    b = '0;
    q = QUAL_NONE;
    if (mode == DMP_ERR) begin
      q = QUAL_ERR_FIRST + QUAL_W'(idx);
      unique case (idx)
        3'h0:    b = single_err_count_in[7:0];
        3'h1:    b = single_err_count_in[15:8];
        3'h2:    b = double_err_count_in;
        default: b = upset_err_count_in;
      endcase
    end else begin
      q = QUAL_CFG_FIRST + QUAL_W'(idx);
      unique case (idx)
        3'h0:    b = s.fine_one;
        3'h1:    b = s.fine_two;
        3'h2:    b = s.coarse;
        3'h3:    b = s.control;
        3'h4:    b = s.id[7:0];
        default: b = BYTE_W'(s.id[ID_W-1:ID_HIGH_LSB]);
      endcase
    end
    return {q, b};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // coarse delay lines

  trcd_dly_if #(.W(BC_USER_LSB + 1), .DW(DLY_W)) low_dl ();
  trcd_dly_if #(.W(BC_USER_W + 1),   .DW(DLY_W)) usr_dl ();

  assign low_dl.din   = {bcast_valid_in, bcast_data_in[BC_USER_LSB-1:0]};
  assign low_dl.delay = st_ff.coarse[COARSE_LOW_LSB +: DLY_W];
  assign usr_dl.din   = {bcast_valid_in,
                         bcast_data_in[BC_USER_LSB +: BC_USER_W]};
  assign usr_dl.delay = st_ff.coarse[COARSE_USER_LSB +: DLY_W];

  trcd_delay_line #(.W(BC_USER_LSB + 1), .DW(DLY_W), .DEPTH(1 << DLY_W)) u_low (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .dl         (low_dl)
  );

  trcd_delay_line #(.W(BC_USER_W + 1), .DW(DLY_W), .DEPTH(1 << DLY_W)) u_usr (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .dl         (usr_dl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic                      hit;
  logic [BYTE_W+QUAL_W-1:0]  dw;
  logic                      lo_v;
  logic                      us_v;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.stb = 1'b0;
    nxt_st.rst_req = 1'b0;
    nxt_st.bunch_clr = 1'b0;
    nxt_st.event_clr = 1'b0;
    if (!st_ff.id_loaded) begin
      nxt_st.id_loaded = 1'b1;
      nxt_st.id = id_from_prom_in ? id_prom_in : id_pins_in[ID_W-1:0];
    end
    hit = st_ff.id_loaded && addr_frame_valid_in &&
          st_ff.dump == DMP_IDLE &&
          (addr_frame_id_in == st_ff.id ||
           addr_frame_id_in == ID_GENERIC);
    dw = dump_word(st_ff.dump, st_ff.idx, st_ff);
    unique case (st_ff.dump)
      DMP_IDLE: begin
        nxt_st.idx = '0;
      end
      DMP_ERR, DMP_CFG: begin
        nxt_st.stb  = 1'b1;
        nxt_st.qual = dw[BYTE_W +: QUAL_W];
        nxt_st.dat  = dw[BYTE_W-1:0];
        nxt_st.idx  = st_ff.idx + 3'h1;
        if ((st_ff.dump == DMP_ERR && st_ff.idx == ERR_LAST_IDX) ||
            (st_ff.dump == DMP_CFG && st_ff.idx == CFG_LAST_IDX)) begin
          nxt_st.dump = DMP_IDLE;
          nxt_st.idx  = '0;
        end
      end
      default: begin
        nxt_st.dump = DMP_IDLE;
        nxt_st.idx  = '0;
      end
    endcase
    if (hit && addr_frame_ext_in) begin
      nxt_st.sub  = addr_frame_sub_in;
      nxt_st.dat  = addr_frame_data_in;
      nxt_st.qual = QUAL_NONE;
      nxt_st.stb  = 1'b1;
    end else if (hit) begin
      unique case (addr_frame_sub_in)
        SUB_FINE_ONE: nxt_st.fine_one = addr_frame_data_in;
        SUB_FINE_TWO: nxt_st.fine_two = addr_frame_data_in;
        SUB_COARSE:   nxt_st.coarse   = addr_frame_data_in;
        SUB_CONTROL:  nxt_st.control  = addr_frame_data_in;
        SUB_ERR_DUMP: nxt_st.dump     = DMP_ERR;
        SUB_CFG_DUMP: nxt_st.dump     = DMP_CFG;
        SUB_RESET:    nxt_st.rst_req  = 1'b1;
        default:      nxt_st.dump     = st_ff.dump;
      endcase
    end
    if (bcast_valid_in) begin
      nxt_st.bunch_clr = bcast_data_in[BC_BUNCH_BIT];
      nxt_st.event_clr = bcast_data_in[BC_EVENT_BIT];
    end
    lo_v = low_dl.dout[BC_USER_LSB];
    us_v = usr_dl.dout[BC_USER_W];
    nxt_st.lo_stb  = lo_v;
    nxt_st.usr_stb = us_v;
    // field split of the broadcast byte
    nxt_st.bclr_stb = lo_v && low_dl.dout[BC_BUNCH_BIT];
    nxt_st.eclr_stb = lo_v && low_dl.dout[BC_EVENT_BIT];
    if (lo_v) begin
      nxt_st.sys = low_dl.dout[BC_SYS_LSB +: BC_SYS_W];
    end
    if (us_v) begin
      nxt_st.usr = usr_dl.dout[BC_USER_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_ff          <= '0;
      st_ff.fine_one <= FINE_ONE_RST;
      st_ff.fine_two <= FINE_TWO_RST;
      st_ff.coarse   <= COARSE_RST;
      st_ff.control  <= CONTROL_RST;
      st_ff.dump     <= DMP_IDLE;
      st_ff.qual     <= QUAL_NONE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // pins carry identity straps until the identity is taken
  assign ext_bus_oe_out        = st_ff.id_loaded;
  assign ext_subaddress_field_out       = st_ff.sub;
  assign ext_data_out          = st_ff.dat;
  assign ext_qual_out          = st_ff.qual;
  assign ext_data_strobe_out   = st_ff.stb;
  assign fine_delay_one_out    = st_ff.fine_one;
  assign fine_delay_two_out    = st_ff.fine_two;
  assign coarse_delay_out      = st_ff.coarse;
  assign control_out           = st_ff.control;
  assign user_clock_select_out = st_ff.control[CTRL_CLK_SEL_BIT];
  assign reset_request_out     = st_ff.rst_req;
  assign bunch_count_clear_out = st_ff.bunch_clr;
  assign event_count_clear_out = st_ff.event_clr;
  assign bunch_clear_strobe_out    = st_ff.bclr_stb;
  assign event_clear_strobe_out    = st_ff.eclr_stb;
  assign broadcast_out             = {st_ff.usr, st_ff.sys};
  assign broadcast_strobe_low_out  = st_ff.lo_stb;
  assign broadcast_strobe_user_out = st_ff.usr_stb;
endmodule
`default_nettype wire

/* dv/trcd_fe_model.sv */
// front-end model: identity straps on the shared pins, logs strobed bytes
`timescale 1ns/1ps
`default_nettype none
module trcd_fe_model #(
  parameter logic [15:0] STRAP = 16'h2a5c
) (
  // clock
  input  wire logic        clk_sys_in,
  // device pins
  input  wire logic        ext_bus_oe_in,
  input  wire logic [7:0]  ext_subaddress_field_in,
  input  wire logic [7:0]  ext_data_in,
  input  wire logic [3:0]  ext_qual_in,
  input  wire logic        ext_data_strobe_in,
  // straps and counter levels
  output logic      [15:0] id_pins_out,
  output logic      [15:0] single_err_out,
  output logic      [7:0]  double_err_out,
  output logic      [7:0]  upset_err_out
);
  logic [19:0] log_q[$];
  // straps are only seen while the device leaves the pins alone
  assign id_pins_out    = ext_bus_oe_in ? {ext_subaddress_field_in, ext_data_in} : STRAP;
  assign single_err_out = 16'hb2c4;
  assign double_err_out = 8'h5e;
  assign upset_err_out  = 8'h17;
  always @(posedge clk_sys_in) begin
    if (ext_data_strobe_in === 1'b1) begin
      log_q.push_back({ext_qual_in, ext_subaddress_field_in, ext_data_in});
    end
  end
endmodule
`default_nettype wire

/* dv/trcd_decoder_chk.sv */
// port assertions for the command decoder
`timescale 1ns/1ps
`default_nettype none
module trcd_decoder_chk (
  // clock and reset
  input wire logic        clk_sys_in,
  input wire logic        rstn_in,
  // frames
  input wire logic        addr_frame_valid_in,
  input wire logic [13:0] addr_frame_id_in,
  input wire logic        addr_frame_ext_in,
  input wire logic [7:0]  addr_frame_sub_in,
  input wire logic [7:0]  addr_frame_data_in,
  input wire logic        bcast_valid_in,
  input wire logic [7:0]  bcast_data_in,
  // outputs
  input wire logic [7:0]  ext_subaddress_field_out,
  input wire logic [7:0]  ext_data_out,
  input wire logic [3:0]  ext_qual_out,
  input wire logic        ext_data_strobe_out,
  input wire logic [7:0]  coarse_delay_out,
  input wire logic [7:0]  control_out,
  input wire logic        user_clock_select_out,
  input wire logic        reset_request_out,
  input wire logic        bunch_count_clear_out,
  input wire logic        bunch_clear_strobe_out,
  input wire logic [7:2]  broadcast_out,
  input wire logic        broadcast_strobe_low_out
);
  logic [3:0] gap_ff;
  logic [1:0] up_ff;
  // cycles since last frame and since reset release, saturating
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gap_ff <= 4'h0;
      up_ff  <= 2'h0;
    end else begin
      gap_ff <= addr_frame_valid_in ? 4'h0 : gap_ff + 4'(gap_ff != 4'hf);
      up_ff  <= up_ff + 2'(up_ff != 2'h3);
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // a gap of eight means no dump can still be running
  sequence int_cmd(logic [7:0] s);
    addr_frame_valid_in && !addr_frame_ext_in && addr_frame_sub_in == s
      && addr_frame_id_in == 14'h0 && gap_ff > 4'h7;
  endsequence
  sequence strobed(logic [3:0] q);
    ext_data_strobe_out && ext_qual_out == q;
  endsequence
  sequence cfg_bytes;
    strobed(4'h5) ##1 strobed(4'h6) ##1 strobed(4'h7)
      ##0 ext_data_out == coarse_delay_out ##1 strobed(4'h8)
      ##0 ext_data_out == control_out ##1 strobed(4'h9) ##1 strobed(4'ha);
  endsequence
  chk_ext_echo: assert property (
    ext_data_strobe_out && ext_qual_out == 4'h0 |->
      $past(addr_frame_valid_in && addr_frame_ext_in)
      && ext_subaddress_field_out == $past(addr_frame_sub_in)
      && ext_data_out == $past(addr_frame_data_in))
    else $error("external command not echoed");
  chk_coarse_write: assert property (
    up_ff == 2'h3 && !$stable(coarse_delay_out) |->
      $past(addr_frame_valid_in && !addr_frame_ext_in
      && addr_frame_sub_in == 8'h02)
      && coarse_delay_out == $past(addr_frame_data_in))
    else $error("coarse delay changed without a write");
  chk_clk_select: assert property (
    user_clock_select_out == control_out[2])
    else $error("user clock select differs from control");
  chk_err_dump: assert property (
    int_cmd(8'h04) |-> ##2 strobed(4'h1) ##1 strobed(4'h2) ##1 strobed(4'h3)
      ##1 strobed(4'h4) ##1 !ext_data_strobe_out)
    else $error("error dump sequence wrong");
  chk_cfg_dump: assert property (
    int_cmd(8'h05) |-> ##2 cfg_bytes ##1 !ext_data_strobe_out)
    else $error("config dump sequence wrong");
  chk_reset_cmd: assert property (
    int_cmd(8'h06) |=> reset_request_out ##1 !reset_request_out)
    else $error("reset command not pulsed");
  chk_reset_cause: assert property (
    reset_request_out |-> $past(addr_frame_valid_in && !addr_frame_ext_in
      && addr_frame_sub_in == 8'h06))
    else $error("reset request without command");
  chk_count_clear: assert property (
    up_ff != 2'h0 |->
      bunch_count_clear_out == $past(bcast_valid_in && bcast_data_in[0]))
    else $error("bunch counter clear wrong");
  chk_strobe_align: assert property (
    bunch_clear_strobe_out |-> broadcast_strobe_low_out)
    else $error("bunch strobe without low strobe");
  chk_low_delay: assert property (
    bcast_valid_in && coarse_delay_out == 8'h00 ##1 coarse_delay_out == 8'h00
      |=> broadcast_strobe_low_out
      && broadcast_out[5:2] == $past(bcast_data_in[5:2], 2))
    else $error("undelayed broadcast late or wrong");
endmodule
bind trcd_decoder trcd_decoder_chk chk_u (
  .clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
  .addr_frame_valid_in(addr_frame_valid_in),
  .addr_frame_id_in(addr_frame_id_in), .addr_frame_ext_in(addr_frame_ext_in),
  .addr_frame_sub_in(addr_frame_sub_in),
  .addr_frame_data_in(addr_frame_data_in),
  .bcast_valid_in(bcast_valid_in), .bcast_data_in(bcast_data_in),
  .ext_subaddress_field_out(ext_subaddress_field_out), .ext_data_out(ext_data_out),
  .ext_qual_out(ext_qual_out), .ext_data_strobe_out(ext_data_strobe_out),
  .coarse_delay_out(coarse_delay_out), .control_out(control_out),
  .user_clock_select_out(user_clock_select_out),
  .reset_request_out(reset_request_out),
  .bunch_count_clear_out(bunch_count_clear_out),
  .bunch_clear_strobe_out(bunch_clear_strobe_out),
  .broadcast_out(broadcast_out),
  .broadcast_strobe_low_out(broadcast_strobe_low_out));
`default_nettype wire

/* dv/trcd_decoder_tb.sv */
// self-checking bench for the command decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("Error at %0t: got %0h expected %0h", $time, a, b); end end
module timing_receiver_command_decoder_tb_top;
  import trcd_pkg::*;
  localparam logic [15:0] STRAP  = 16'h2a5c;
  localparam logic [13:0] OWN_ID = STRAP[13:0];
  localparam logic [13:0] PROM_ID = 14'h1b7e;
  logic        clk_sys_in, rstn_in, fr_valid, fr_ext, bc_valid, prom_sel;
  logic [13:0] fr_id, prom_id;
  logic [7:0]  fr_sub, fr_data, bc_data, d_upset, d_double;
  logic [15:0] id_pins, d_single;
  logic        oe, stb, usel, rst_req, bclr, eclr, bstb, estb, s_low, s_user;
  logic [7:0]  sub_o, dat_o, fine1, fine2, coarse, ctrl;
  logic [3:0]  qual_o;
  logic [7:2]  bcast;
  logic [7:0]  cfg_exp [6];
  int          n_fail;
  int          n_compared;
  trcd_decoder dut_u (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .id_from_prom_in(prom_sel),
    .id_prom_in(prom_id), .id_pins_in(id_pins),
    .addr_frame_valid_in(fr_valid), .addr_frame_id_in(fr_id),
    .addr_frame_ext_in(fr_ext), .addr_frame_sub_in(fr_sub),
    .addr_frame_data_in(fr_data), .bcast_valid_in(bc_valid),
    .bcast_data_in(bc_data), .single_err_count_in(d_single),
    .double_err_count_in(d_double), .upset_err_count_in(d_upset),
    .ext_bus_oe_out(oe), .ext_subaddress_field_out(sub_o), .ext_data_out(dat_o),
    .ext_qual_out(qual_o), .ext_data_strobe_out(stb),
    .fine_delay_one_out(fine1), .fine_delay_two_out(fine2),
    .coarse_delay_out(coarse), .control_out(ctrl),
    .user_clock_select_out(usel), .reset_request_out(rst_req),
    .bunch_count_clear_out(bclr), .event_count_clear_out(eclr),
    .bunch_clear_strobe_out(bstb), .event_clear_strobe_out(estb),
    .broadcast_out(bcast), .broadcast_strobe_low_out(s_low),
    .broadcast_strobe_user_out(s_user));
  trcd_fe_model #(.STRAP(STRAP)) fe_u (
    .clk_sys_in(clk_sys_in), .ext_bus_oe_in(oe), .ext_subaddress_field_in(sub_o),
    .ext_data_in(dat_o), .ext_qual_in(qual_o), .ext_data_strobe_in(stb),
    .id_pins_out(id_pins), .single_err_out(d_single),
    .double_err_out(d_double), .upset_err_out(d_upset));
  //////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  // frame is taken at the second edge; sub and data then show a changed pattern
  task automatic frame(input logic [13:0] id, input logic ext,
                       input logic [7:0] sub, input logic [7:0] dat);
    @(posedge clk_sys_in);
    fr_valid <= 1'b1;
    fr_id    <= id;
    fr_ext   <= ext;
    fr_sub   <= sub;
    fr_data  <= dat;
    @(posedge clk_sys_in);
    fr_valid <= 1'b0;
    fr_sub   <= ~sub;
    fr_data  <= ~dat;
    #1;
  endtask
  task automatic pop_chk(input logic [3:0] q, input logic [7:0] d);
    logic [19:0] e;
    e = 20'hfffff;
    if (fe_u.log_q.size() > 0) e = fe_u.log_q.pop_front();
    `CHK(e[19:16], q)
    `CHK(e[7:0], d)
  endtask
  task automatic bc_chk(input logic [7:0] b, input int lo, input int us);
    int lo_at, us_at, nb;
    lo_at = 0;
    us_at = 0;
    nb    = 0;
    @(posedge clk_sys_in);
    bc_valid <= 1'b1;
    bc_data  <= b;
    @(posedge clk_sys_in);
    bc_valid <= 1'b0;
    bc_data  <= ~b;
    #1;
    `CHK({bclr, eclr}, {b[0], b[1]})
    for (int k = 1; k < 20; k++) begin
      tick(1);
      if (bstb === 1'b1) nb++;
      if (s_low === 1'b1) begin
        lo_at = k;
        `CHK({bstb, estb, bcast[5:2]}, {b[0], b[1], b[5:2]})
      end
      if (s_user === 1'b1) begin
        us_at = k;
        `CHK(bcast[7:6], b[7:6])
      end
    end
    `CHK(lo_at, lo + 1)
    `CHK(us_at, us + 1)
    `CHK(nb, int'(b[0]))
    `CHK(bcast, b[7:2])
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end
  initial begin
    {rstn_in, fr_valid, fr_ext, bc_valid, prom_sel} = 5'h0;
    {fr_id, fr_sub, fr_data, bc_data, prom_id} = 52'h0;
    n_fail     = 0;
    n_compared = 0;
    repeat (5) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    tick(10);
    `CHK({fine1, fine2, coarse, ctrl}, 32'h0)
    bc_chk(8'h24, 0, 0);
    frame(OWN_ID, 1'b1, 8'h9a, 8'h3c);
    frame(OWN_ID ^ 14'h0001, 1'b1, 8'h11, 8'h22);
    tick(4);
    `CHK(fe_u.log_q.size(), 1)
    pop_chk(QUAL_NONE, 8'h3c);
    `CHK(sub_o, 8'h9a)
    frame(14'h0, 1'b0, 8'h00, 8'h5a);
    `CHK(fine1, 8'h5a)
    frame(14'h0, 1'b0, 8'h01, 8'ha5);
    frame(OWN_ID, 1'b0, 8'h02, 8'h31);
    frame(14'h0, 1'b0, 8'h03, 8'h04);
    frame(14'h0, 1'b0, 8'h07, 8'hff);
    tick(1);
    `CHK({fine1, fine2, coarse, ctrl}, 32'h5aa53104)
    `CHK(usel, 1'b1)
    `CHK(fe_u.log_q.size(), 0)
    tick(8);
    frame(14'h0, 1'b0, 8'h04, 8'h77);
    frame(OWN_ID, 1'b1, 8'h33, 8'h44);
    tick(8);
    `CHK(fe_u.log_q.size(), 4)
    pop_chk(4'h1, 8'hc4);
    pop_chk(4'h2, 8'hb2);
    pop_chk(4'h3, 8'h5e);
    pop_chk(4'h4, 8'h17);
    frame(14'h0, 1'b0, 8'h05, 8'h00);
    tick(8);
    cfg_exp = '{8'h5a, 8'ha5, 8'h31, 8'h04, OWN_ID[7:0], {2'b00, OWN_ID[13:8]}};
    foreach (cfg_exp[i]) pop_chk(4'(i + 5), cfg_exp[i]);
    frame(14'h0, 1'b0, 8'h06, 8'h00);
    `CHK(rst_req, 1'b1)
    tick(1);
    `CHK(rst_req, 1'b0)
    bc_chk(8'h24, 1, 3);
    bc_chk(8'hd9, 1, 3);
    bc_chk(8'h6e, 1, 3);
    bc_chk(8'hb3, 1, 3);
    `CHK(oe, 1'b1)
    // mid-run reset, identity now taken from the prom input
    @(posedge clk_sys_in);
    rstn_in  <= 1'b0;
    prom_sel <= 1'b1;
    prom_id  <= PROM_ID;
    tick(5);
    `CHK({oe, ctrl, rst_req}, 10'h000)
    @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    tick(10);
    `CHK({oe, coarse}, 9'h100)
    frame(OWN_ID, 1'b1, 8'h12, 8'h34);
    frame(PROM_ID, 1'b1, 8'h56, 8'h78);
    tick(2);
    `CHK(fe_u.log_q.size(), 1)
    pop_chk(QUAL_NONE, 8'h78);
    `CHK(sub_o, 8'h56)
    end_of_test();
  end
endmodule
`default_nettype wire
